// ==== src/boot_strap_config_decoder.sv ====
// Boot-time strap decode, EEPROM fetch and host configuration load
//
// Summary of operation
// - Sample both straps first; derive address index and policy before loading.
// - After sampling, try to fetch configuration over the master port.
// - Configuration EEPROM sits at 7-bit address 0x50.
// - Without EEPROM acknowledge, wait for the host to load configuration.
// - Always-sink pairs pick indices 1-4; sink always on, PD off until loaded.
// - Min 3.0 A pairs pick indices 1-4; sink needs 3.0 A.
// - Min 1.5 A pairs pick indices 1-4; sink needs 1.5 A.
// - High-voltage pairs pick indices 1-4; sink on during implicit contract.
// - High-voltage policy enters application mode, enables PD, caps at 20 V.
// - Sink-off pairs pick indices 1-4; sink off, PD off until loaded.
// - Under sink-off policy, loaded configuration may make the device source-only.
// - Each Type-C port answers on its own host slave address.
// - Sub-address carries host commands and their responses.
// - Only port A address answers during boot; port B after.
// - Index sets address bits 1:0; bit 2 marks port B.
`timescale 1ns/100ps
`default_nettype none
`include "boot_cfg_defs.svh"
module boot_strap_config_decoder (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Strap inputs, decoded levels
    input wire logic [2:0] strapInputA,
    input wire logic [2:0] strapInputB,
    // Config master port, open drain
    input wire logic masterSclIn,
    output logic masterSclOut,
    output logic masterSclOe,
    input wire logic masterSdaIn,
    output logic masterSdaOut,
    output logic masterSdaOe,
    // Host slave port, byte level
    input wire logic hostStrobe,
    input wire logic hostWrite,
    input wire logic [6:0] hostAddr,
    input wire logic [7:0] hostSubAddr,
    input wire logic [7:0] hostWrData,
    output logic hostAck,
    output logic hostPort,
    output logic [7:0] hostRdData,
    // Attached source
    input wire logic sourceAttached,
    input wire boot_cfg_pkg::src_current_t sourceCurrent,
    // Power path and status
    output boot_cfg_pkg::policy_t sinkPolicy,
    output boot_cfg_pkg::addr_index_t addrIndex,
    output logic sinkEnable,
    output logic pdEnable,
    output logic applicationMode,
    output logic [15:0] contractLimitMv,
    output logic sourceOnly,
    output logic bootDone,
    output logic configLoaded,
    output logic eepromMissing
);
    import boot_cfg_pkg::*;

    boot_state_t state;
    boot_state_t next_state;
    logic [5:0] strapCode;
    logic strapValid;
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic [2:0] bitCnt;
    logic [2:0] next_bitCnt;
    logic [1:0] byteCnt;
    logic [1:0] next_byteCnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [15:0] cfgData;
    logic [15:0] next_cfg;
    logic next_sclOe;
    logic next_sdaOe;
    logic next_missing;
    logic next_loaded;
    logic [`QCNT_W-1:0] qCnt;

    strap_cfg_if strapIf ();

    assign strapIf.strapCode = strapCode;

    strap_policy_decode u_decode (
        .cfg(strapIf.decoder)
    );

    // Quarter-period timebase for the master port
    wire logic qTick;
    wire logic stretched;
    wire logic busState;
    wire logic busStep;
    wire logic setupEnd;
    wire logic riseEnd;
    wire logic highEnd;
    wire logic fallEnd;
    wire logic slotState;
    wire logic lastByte;
    wire logic txBit;

    assign qTick = qCnt == `QCNT_W'(`SCL_QUARTER_CYC - 1);
    // Slave may hold SCL low; high phase waits for it
    assign stretched = (phase == `PH_HIGH) & ~masterSclIn;
    assign busState = (state != ST_SAMPLE) & (state != ST_WAIT_HOST) & (state != ST_RUN);
    assign busStep = qTick & ~stretched & busState;
    assign setupEnd = busStep & (phase == `PH_SETUP);
    assign riseEnd = busStep & (phase == `PH_RISE);
    assign highEnd = busStep & (phase == `PH_HIGH);
    assign fallEnd = busStep & (phase == `PH_FALL);
    assign slotState = (state == ST_ADDR) | (state == ST_ADDR_ACK) |
                       (state == ST_READ) | (state == ST_MASTER_ACK);
    assign lastByte = byteCnt == `LAST_BYTE;
    // Address bits, then released SDA; NACK ends the last byte
    assign txBit = (state == ST_ADDR) ? shift[7] :
                   (state == ST_MASTER_ACK) ? lastByte : 1'b1;

    // Host port address decode
    wire logic hitA;
    wire logic hitB;
    wire logic hostHit;
    wire logic cfgWrite;
    wire logic [7:0] statusByte;
    wire logic [7:0] readMux;

    slave_addr_match #(.PORT_B(1'b0)) u_match_a (
        .addr(hostAddr),
        .index(addrIndex),
        .enable(1'b1),
        .hit(hitA)
    );

    slave_addr_match #(.PORT_B(1'b1)) u_match_b (
        .addr(hostAddr),
        .index(addrIndex),
        .enable(bootDone),
        .hit(hitB)
    );

    assign hostHit = hostStrobe & (hitA | hitB);
    // Boot loads go through port A only
    assign cfgWrite = hostStrobe & hostWrite & hitA & (hostSubAddr == `SUB_CFG_LOAD) &
                      (state == ST_WAIT_HOST);
    assign statusByte = {bootDone, configLoaded, eepromMissing, sinkPolicy, addrIndex};
    assign readMux = (hostSubAddr == `SUB_STATUS) ? statusByte :
                     (hostSubAddr == `SUB_CONFIG) ? cfgData[7:0] : 8'h00;

    // Dead-battery sink decisions
    wire logic hvPolicy;
    wire logic policyAllows;
    wire logic sinkAllowed;
    wire logic appActive;

    assign hvPolicy = sinkPolicy == HIGH_VOLTAGE_NEGOTIATE_POLICY;
    assign policyAllows = (sinkPolicy == SINK_ALWAYS_POLICY) |
        ((sinkPolicy == SINK_MIN_3A_POLICY) & (sourceCurrent >= `CUR_3A0)) |
        ((sinkPolicy == SINK_MIN_1A5_POLICY) & (sourceCurrent >= `CUR_1A5)) |
        hvPolicy;
    // Sink-off never enables; loaded source-only role blocks sinking
    assign sinkAllowed = sourceAttached & policyAllows & ~sourceOnly;
    assign appActive = configLoaded | (hvPolicy & strapValid);

    // Boot sequencer and master bit engine
    always_comb begin
        next_state = state;
        next_phase = phase;
        next_bitCnt = bitCnt;
        next_byteCnt = byteCnt;
        next_shift = shift;
        next_cfg = cfgData;
        next_sclOe = masterSclOe;
        next_sdaOe = masterSdaOe;
        next_missing = eepromMissing;
        next_loaded = configLoaded;
        if (busStep) begin
            next_phase = phase + 2'h1;
        end
        if (slotState & setupEnd) begin
            next_sdaOe = ~txBit;
        end
        if (slotState & riseEnd) begin
            next_sclOe = 1'b0;
        end
        if (slotState & fallEnd) begin
            next_sclOe = 1'b1;
        end
        case (state)
            ST_SAMPLE: begin
                next_phase = `PH_SETUP;
                next_state = ST_START;
            end
            ST_START: begin
                if (highEnd) begin
                    next_sdaOe = 1'b1;
                end
                if (fallEnd) begin
                    next_sclOe = 1'b1;
                    next_shift = {`EEPROM_ADDR, `I2C_READ};
                    next_bitCnt = 3'h0;
                    next_state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (fallEnd && bitCnt == `LAST_BIT) begin
                    next_state = ST_ADDR_ACK;
                end else if (fallEnd) begin
                    next_bitCnt = bitCnt + 3'h1;
                    next_shift = {shift[6:0], 1'b0};
                end
            end
            ST_ADDR_ACK: begin
                if (highEnd) begin
                    next_shift = {shift[6:0], masterSdaIn};
                end
                if (fallEnd && shift[0]) begin
                    next_missing = 1'b1;
                    next_state = ST_STOP;
                end else if (fallEnd) begin
                    next_bitCnt = 3'h0;
                    next_byteCnt = 2'h0;
                    next_state = ST_READ;
                end
            end
            ST_READ: begin
                if (highEnd) begin
                    next_shift = {shift[6:0], masterSdaIn};
                end
                if (fallEnd && bitCnt == `LAST_BIT) begin
                    next_state = ST_MASTER_ACK;
                end else if (fallEnd) begin
                    next_bitCnt = bitCnt + 3'h1;
                end
            end
            ST_MASTER_ACK: begin
                if (fallEnd) begin
                    next_cfg = {cfgData[7:0], shift};
                    next_byteCnt = byteCnt + 2'h1;
                    next_bitCnt = 3'h0;
                    next_state = lastByte ? ST_STOP : ST_READ;
                end
            end
            ST_STOP: begin
                if (setupEnd) begin
                    next_sdaOe = 1'b1;
                end
                if (riseEnd) begin
                    next_sclOe = 1'b0;
                end
                if (fallEnd) begin
                    next_sdaOe = 1'b0;
                    next_loaded = ~eepromMissing;
                    next_byteCnt = 2'h0;
                    next_state = eepromMissing ? ST_WAIT_HOST : ST_RUN;
                end
            end
            ST_WAIT_HOST: begin
                if (cfgWrite) begin
                    next_cfg = {cfgData[7:0], hostWrData};
                    next_byteCnt = byteCnt + 2'h1;
                end
                if (cfgWrite && lastByte) begin
                    next_loaded = 1'b1;
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_state = ST_RUN;
            end
            default: begin
                next_state = ST_SAMPLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            qCnt <= '0;
        end else if (qTick) begin
            qCnt <= '0;
        end else begin
            qCnt <= qCnt + `QCNT_W'(1);
        end
    end

    // Straps are caught once, on the first edge after reset release
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            strapCode <= 6'h00;
            strapValid <= 1'b0;
        end else if (state == ST_SAMPLE) begin
            strapCode <= {strapInputA, strapInputB};
            strapValid <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state <= ST_SAMPLE;
            phase <= `PH_SETUP;
            bitCnt <= 3'h0;
            byteCnt <= 2'h0;
            shift <= 8'h00;
            cfgData <= 16'h0000;
        end else begin
            state <= next_state;
            phase <= next_phase;
            bitCnt <= next_bitCnt;
            byteCnt <= next_byteCnt;
            shift <= next_shift;
            cfgData <= next_cfg;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            masterSclOe <= 1'b0;
            masterSdaOe <= 1'b0;
            masterSclOut <= 1'b0;
            masterSdaOut <= 1'b0;
            eepromMissing <= 1'b0;
            configLoaded <= 1'b0;
        end else begin
            masterSclOe <= next_sclOe;
            masterSdaOe <= next_sdaOe;
            masterSclOut <= 1'b0;
            masterSdaOut <= 1'b0;
            eepromMissing <= next_missing;
            configLoaded <= next_loaded;
        end
    end

    // Policy outputs follow the latched straps
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sinkPolicy <= SINK_OFF_POLICY;
            addrIndex <= `IDX_1;
            sinkEnable <= 1'b0;
            pdEnable <= 1'b0;
            applicationMode <= 1'b0;
            contractLimitMv <= 16'h0000;
            sourceOnly <= 1'b0;
            bootDone <= 1'b0;
        end else begin
            sinkPolicy <= strapIf.policy;
            addrIndex <= strapIf.index;
            sinkEnable <= sinkAllowed;
            pdEnable <= appActive;
            applicationMode <= appActive;
            contractLimitMv <= appActive ? `MAX_CONTRACT_MV : 16'h0000;
            sourceOnly <= configLoaded & cfgData[`SRC_ONLY_BIT];
            bootDone <= state == ST_RUN;
        end
    end

    // Host answers one cycle after the strobe
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            hostAck <= 1'b0;
            hostPort <= 1'b0;
            hostRdData <= 8'h00;
        end else begin
            hostAck <= hostHit;
            if (hostHit) begin
                hostPort <= hitB;
            end
            if (hostHit && !hostWrite) begin
                hostRdData <= readMux;
            end
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    a_strap_first: assert property ((state == ST_SAMPLE) |=> (strapValid && state == ST_START))
        else $error("strap sample did not precede the fetch");
    a_fetch_no_load: assert property ((state == ST_START) |-> (strapValid && !configLoaded))
        else $error("fetch started without straps or after load");
    a_eeprom_addr: assert property ((state == ST_ADDR && bitCnt == 3'h0) |-> shift == 8'hA1)
        else $error("EEPROM address byte wrong");
    a_nack_waits: assert property ((state == ST_ADDR_ACK && fallEnd && shift[0]) |=> (state == ST_STOP && eepromMissing))
        else $error("missing EEPROM not flagged");
    a_wait_holds: assert property ((state == ST_WAIT_HOST && !cfgWrite) |=> (state == ST_WAIT_HOST && !bootDone))
        else $error("left host wait without a load");
    a_sink_always: assert property ((sinkPolicy == SINK_ALWAYS_POLICY && sourceAttached && !configLoaded) |=> (sinkEnable && !pdEnable))
        else $error("always-sink policy did not enable sink");
    a_sink_3a: assert property ((sinkPolicy == SINK_MIN_3A_POLICY && sourceCurrent < 2'h2) |=> !sinkEnable)
        else $error("sink enabled below 3.0 A");
    a_sink_1a5: assert property ((sinkPolicy == SINK_MIN_1A5_POLICY && sourceCurrent == 2'h0) |=> !sinkEnable)
        else $error("sink enabled below 1.5 A");
    a_hv_mode: assert property ((sinkPolicy == HIGH_VOLTAGE_NEGOTIATE_POLICY && strapValid) |=> (applicationMode && pdEnable && contractLimitMv == 16'h4E20))
        else $error("high-voltage policy did not start negotiation");
    a_sink_off: assert property ((sinkPolicy == SINK_OFF_POLICY && !configLoaded) |=> (!sinkEnable && !pdEnable))
        else $error("sink-off policy enabled a path");
    a_port_b_boot: assert property ((hostStrobe && !bootDone && hostAddr == {4'h4, 1'b1, addrIndex}) |=> !hostAck)
        else $error("port B answered during boot");
    a_port_a_ack: assert property ((hostStrobe && hostAddr == {4'h4, 1'b0, addrIndex}) |=> (hostAck && !hostPort))
        else $error("port A address not answered");

    c_eeprom_load: cover property (configLoaded && !eepromMissing);
    c_host_load: cover property (configLoaded && eepromMissing);
    c_port_b: cover property (hostAck && hostPort);
    c_hv_app: cover property (applicationMode && !configLoaded);
endmodule // boot_strap_config_decoder
`default_nettype wire

// ==== common/boot_cfg_defs.svh ====
// Named constants for the boot strap configuration decoder
`ifndef BOOT_CFG_DEFS_SVH
`define BOOT_CFG_DEFS_SVH

`define EEPROM_ADDR 7'h50
`define I2C_READ 1'h1
`define SLAVE_ADDR_HI 4'h4
`define IDX_1 2'h0
`define IDX_2 2'h1
`define IDX_3 2'h2
`define IDX_4 2'h3
`define CUR_1A5 2'h1
`define CUR_3A0 2'h2
`define SRC_ONLY_BIT 0
`define MAX_CONTRACT_MV 16'h4E20
`define SUB_STATUS 8'h03
`define SUB_CFG_LOAD 8'h10
`define SUB_CONFIG 8'h11
`define CFG_BYTES 2
`define LAST_BYTE 2'h1
`define LAST_BIT 3'h7
`define PH_SETUP 2'h0
`define PH_RISE 2'h1
`define PH_HIGH 2'h2
`define PH_FALL 2'h3
`define CLK_MHZ 10
`define SCL_QUARTER_NS 2500
`define SCL_QUARTER_CYC ((`SCL_QUARTER_NS * `CLK_MHZ + 999) / 1000)
`define QCNT_W 5

`endif

// ==== common/boot_cfg_pkg.sv ====
// Types shared by the boot strap configuration decoder
package boot_cfg_pkg;
    typedef enum logic [2:0] {
        SINK_ALWAYS_POLICY,
        SINK_MIN_3A_POLICY,
        SINK_MIN_1A5_POLICY,
        HIGH_VOLTAGE_NEGOTIATE_POLICY,
        SINK_OFF_POLICY
    } policy_t;
    typedef logic [1:0] addr_index_t;
    typedef logic [1:0] src_current_t;
    typedef enum logic [3:0] {
        ST_SAMPLE,
        ST_START,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_READ,
        ST_MASTER_ACK,
        ST_STOP,
        ST_WAIT_HOST,
        ST_RUN
    } boot_state_t;
endpackage

// ==== common/strap_cfg_if.sv ====
// Carrier between the strap latch and the strap decoder
`timescale 1ns/100ps
`default_nettype none
interface strap_cfg_if;
    import boot_cfg_pkg::*;
    logic [5:0] strapCode;
    policy_t policy;
    addr_index_t index;
    modport decoder (input strapCode, output policy, output index);
    modport user (output strapCode, input policy, input index);
endinterface // strap_cfg_if
`default_nettype wire

// ==== src/strap_policy_decode.sv ====
// Strap pair to address index and dead-battery policy decoder
`timescale 1ns/100ps
`default_nettype none
`include "boot_cfg_defs.svh"
module strap_policy_decode (
    // Strap code in, policy and index out
    strap_cfg_if.decoder cfg
);
    import boot_cfg_pkg::*;

    always_comb begin
        case (cfg.strapCode)
            6'h3D, 6'h2D, 6'h10, 6'h0F: cfg.policy = SINK_ALWAYS_POLICY;
            6'h3C, 6'h24, 6'h18, 6'h17: cfg.policy = SINK_MIN_3A_POLICY;
            6'h3E, 6'h36, 6'h35, 6'h37: cfg.policy = SINK_MIN_1A5_POLICY;
            6'h3B, 6'h1B, 6'h20, 6'h1F: cfg.policy = HIGH_VOLTAGE_NEGOTIATE_POLICY;
            default: cfg.policy = SINK_OFF_POLICY;
        endcase
    end

    always_comb begin
        case (cfg.strapCode)
            6'h2D, 6'h24, 6'h36, 6'h1B, 6'h00: cfg.index = `IDX_2;
            6'h10, 6'h18, 6'h35, 6'h20, 6'h30: cfg.index = `IDX_3;
            6'h0F, 6'h17, 6'h37, 6'h1F, 6'h2F: cfg.index = `IDX_4;
            // Unlisted pairs fall back to index 1
            default: cfg.index = `IDX_1;
        endcase
    end
endmodule // strap_policy_decode
`default_nettype wire

// ==== src/slave_addr_match.sv ====
// Host slave address comparator for one Type-C port
`timescale 1ns/100ps
`default_nettype none
`include "boot_cfg_defs.svh"
module slave_addr_match #(
    parameter logic PORT_B = 1'b0
) (
    // Request address and strap index
    input wire logic [6:0] addr,
    input wire logic [1:0] index,
    input wire logic enable,
    // Match result
    output wire logic hit
);
    wire logic [6:0] expected;

    // Index in bits 1:0, port in bit 2
    assign expected = {`SLAVE_ADDR_HI, PORT_B, index};
    assign hit = enable & (addr == expected);
endmodule // slave_addr_match
`default_nettype wire

// ==== verification/cfg_eeprom_model.sv ====
// Behavioural configuration EEPROM on the open-drain master port
`timescale 1ns/100ps
`default_nettype none
module cfg_eeprom_model (
    // Bus wires and presence
    input wire logic scl,
    input wire logic sda,
    input wire logic present,
    input wire logic [15:0] image,
    // Pull-down on data, released means pull-up level
    output logic sdaLow
);
    int bitCnt = 0;
    int byteIdx = 0;
    logic active = 1'b0;
    logic reading = 1'b0;
    logic [7:0] shifter = 8'h00;
    initial sdaLow = 1'b0;
    // One model per controller, never shared
    always @(negedge sda) if (scl) begin
        active = 1'b1;
        reading = 1'b0;
        bitCnt = 0;
    end
    always @(posedge sda) if (scl) active = 1'b0;
    always @(posedge scl) if (active) begin
        if (bitCnt < 8 && !reading) shifter = {shifter[6:0], sda};
        if (bitCnt == 8) begin
            byteIdx = reading ? byteIdx + 1 : 0;
            reading = reading ? ~sda : sdaLow;
        end
        bitCnt = (bitCnt == 8) ? 0 : bitCnt + 1;
    end
    // Data changes only while the clock is low
    always @(negedge scl) begin
        sdaLow = 1'b0;
        if (active && !reading && bitCnt == 8) sdaLow = present && shifter == 8'hA1;
        if (active && reading && bitCnt < 8 && byteIdx < 2) sdaLow = ~image[15 - 8 * byteIdx - bitCnt];
    end
endmodule // cfg_eeprom_model
`default_nettype wire

// ==== verification/boot_strap_config_decoder_bench.sv ====
// Self-checking bench for the boot strap configuration decoder
`timescale 1ns/100ps
`default_nettype none
module boot_strap_config_decoder_bench;
    import boot_cfg_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [2:0] strapInputA = 3'h0;
    logic [2:0] strapInputB = 3'h0;
    logic hostStrobe = 1'b0;
    logic hostWrite = 1'b0;
    logic [6:0] hostAddr = 7'h00;
    logic [7:0] hostSubAddr = 8'h00;
    logic [7:0] hostWrData = 8'h00;
    logic sourceAttached = 1'b0;
    src_current_t sourceCurrent = 2'h0;
    logic present = 1'b0;
    logic [15:0] image = 16'h5A3C;
    logic sclOe, sdaOe, eeLow, hostAck, hostPort, sinkEnable, pdEnable, applicationMode;
    logic sourceOnly, bootDone, configLoaded, eepromMissing, sclOut, sdaOut;
    logic [7:0] hostRdData;
    logic [15:0] contractLimitMv;
    policy_t sinkPolicy;
    addr_index_t addrIndex;
    wire scl = ~sclOe;
    wire sda = ~(sdaOe | eeLow);
    int n_errors = 0;
    int checked = 0;
    int pol;
    int idx;
    // Strap codes a*8+b, four per policy in index order
    int tbl[20] = '{'o75, 'o55, 'o20, 'o17, 'o74, 'o44, 'o30, 'o27, 'o76, 'o66,
                    'o65, 'o67, 'o73, 'o33, 'o40, 'o37, 'o70, 'o00, 'o60, 'o57};
    boot_strap_config_decoder boot_strap_config_decoder_inst (.sys_clk(sys_clk), .reset(reset),
        .strapInputA(strapInputA), .strapInputB(strapInputB), .masterSclIn(scl),
        .masterSclOut(sclOut), .masterSclOe(sclOe), .masterSdaIn(sda), .masterSdaOut(sdaOut),
        .masterSdaOe(sdaOe), .hostStrobe(hostStrobe), .hostWrite(hostWrite),
        .hostAddr(hostAddr), .hostSubAddr(hostSubAddr), .hostWrData(hostWrData),
        .hostAck(hostAck), .hostPort(hostPort), .hostRdData(hostRdData),
        .sourceAttached(sourceAttached), .sourceCurrent(sourceCurrent),
        .sinkPolicy(sinkPolicy), .addrIndex(addrIndex), .sinkEnable(sinkEnable),
        .pdEnable(pdEnable), .applicationMode(applicationMode),
        .contractLimitMv(contractLimitMv), .sourceOnly(sourceOnly), .bootDone(bootDone),
        .configLoaded(configLoaded), .eepromMissing(eepromMissing));
    cfg_eeprom_model cfg_eeprom_model_inst (.scl(scl), .sda(sda), .present(present),
        .image(image), .sdaLow(eeLow));
    initial forever #50 sys_clk = ~sys_clk;
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic boot(input int a, input int b, input logic ee);
        @(posedge sys_clk);
        reset <= 1'b1;
        present <= ee;
        strapInputA <= 3'(a);
        strapInputB <= 3'(b);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        pol = 4;
        idx = 0;
        foreach (tbl[i]) if (tbl[i] == a * 8 + b) begin
            pol = i / 4;
            idx = i % 4;
        end
        repeat (4) @(posedge sys_clk);
        #1;
    endtask
    task automatic host(input logic wr, input logic [6:0] ad, input logic [7:0] sub,
                        input logic [7:0] d, input logic ack);
        @(posedge sys_clk);
        hostStrobe <= 1'b1;
        hostWrite <= wr;
        hostAddr <= ad;
        hostSubAddr <= sub;
        hostWrData <= d;
        @(posedge sys_clk);
        hostStrobe <= 1'b0;
        #1 check(hostAck, ack, "hostAck");
    endtask
    // Sink path allowance from policy and offered current
    function automatic logic sinkExp(int p);
        return sourceAttached && (p == 0 || p == 3 || (p == 1 && sourceCurrent >= 2)
            || (p == 2 && sourceCurrent != 0));
    endfunction
    initial begin
        #4_000_000;
        n_errors++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h9fca));
        // Every strap code, listed and unlisted, EEPROM absent
        for (int c = 0; c < 64; c++) begin
            boot(c / 8, c % 8, 1'b0);
            check(sinkPolicy, 16'(pol), "sinkPolicy");
            check(addrIndex, 16'(idx), "addrIndex");
            check(pdEnable, pol == 3, "pdEnable");
            check(applicationMode, pol == 3, "applicationMode");
            check(contractLimitMv, pol == 3 ? 16'h4E20 : 16'h0000, "limit");
            @(posedge sys_clk);
            sourceAttached <= 1'($urandom);
            sourceCurrent <= 2'($urandom);
            repeat (2) @(posedge sys_clk);
            #1 check(sinkEnable, sinkExp(pol), "sinkEnable");
            host(1'b0, {4'h4, 1'b0, idx[1:0]}, 8'h03, 8'h00, 1'b1);
            check(hostRdData, {3'h0, pol[2:0], idx[1:0]}, "status");
            host(1'b0, {4'h4, 1'b1, idx[1:0]}, 8'h03, 8'h00, 1'b0);
            host(1'b0, {4'h4, 1'b0, ~idx[1], idx[0]}, 8'h03, 8'h00, 1'b0);
        end
        $display("strap table test done");
        // No EEPROM: host pushes the configuration on port A
        boot(7, 0, 1'b0);
        for (int w = 0; w < 8000 && eepromMissing !== 1'b1; w++) @(posedge sys_clk);
        #1 check(eepromMissing, 1'b1, "eepromMissing");
        check(configLoaded, 1'b0, "configLoaded");
        // Stop condition still runs after the NACK; configuration stays unloaded without a host write
        repeat (150) @(posedge sys_clk);
        #1 check(configLoaded, 1'b0, "configLoaded");
        host(1'b0, 7'h24, 8'h03, 8'h00, 1'b0);
        host(1'b1, 7'h20, 8'h10, 8'h12, 1'b1);
        host(1'b1, 7'h20, 8'h10, 8'h35, 1'b1);
        repeat (2) @(posedge sys_clk);
        #1 check(bootDone, 1'b1, "bootDone");
        check(pdEnable, 1'b1, "pdEnable");
        check(sourceOnly, 1'b1, "sourceOnly");
        host(1'b0, 7'h20, 8'h11, 8'h00, 1'b1);
        check(hostRdData, 8'h35, "cfgRead");
        host(1'b0, 7'h24, 8'h03, 8'h00, 1'b1);
        check(hostPort, 1'b1, "hostPort");
        $display("host load test done");
        // EEPROM present: fetch at 0x50, later host writes ignored
        boot(0, 0, 1'b1);
        for (int w = 0; w < 8000 && configLoaded !== 1'b1; w++) @(posedge sys_clk);
        #1 check(configLoaded, 1'b1, "configLoaded");
        check(eepromMissing, 1'b0, "eepromMissing");
        check({sclOut, sdaOut}, 16'h0000, "openDrainOut");
        host(1'b1, 7'h21, 8'h10, 8'hFF, 1'b1);
        host(1'b1, 7'h21, 8'h10, 8'hFF, 1'b1);
        host(1'b0, 7'h21, 8'h11, 8'h00, 1'b1);
        check(hostRdData, image[7:0], "cfgRead");
        check(sourceOnly, 1'b0, "sourceOnly");
        $display("eeprom fetch test done");
        end_sim();
    end
endmodule // boot_strap_config_decoder_bench
`default_nettype wire
